// ### design/midi_uart_pkg.sv
/*
 * shared constants and carriers for the midi uart port emulation.
 * assumes a 100 MHz core clock and an isa-style byte-wide host bus.
 */
package midi_uart_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BAUD_HZ = 31_250;
	localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_HZ;
	localparam logic [9:0] BASE_DEFAULT = 10'h330;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DECODE_W = 10;
	localparam logic OFFSET_DATA = 1'b0;
	localparam logic OFFSET_CMD = 1'b1;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned TXS_BIT = 6;
	localparam int unsigned RXS_BIT = 7;
	localparam logic [7:0] CMD_ENTER_UART = 8'h3F;
	localparam logic [7:0] CMD_LEAVE_UART = 8'hFF;
	localparam logic [7:0] ACK_BYTE = 8'hFE;
	localparam logic [7:0] REPLY_ZERO = 8'h00;
	localparam logic [7:0] CMD_AC = 8'hAC;
	localparam logic [7:0] REPLY_AC = 8'h15;
	localparam logic [7:0] CMD_AD = 8'hAD;
	localparam logic [7:0] REPLY_AD = 8'h01;
	localparam logic [7:0] CMD_AF = 8'hAF;
	localparam logic [7:0] REPLY_AF = 8'h64;
	localparam logic [7:0] CMD_AB = 8'hAB;
	localparam logic [4:0] CMD_A_GROUP = 5'h14;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} host_req_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_START = 2'b01,
		TX_DATA = 2'b11,
		TX_STOP = 2'b10
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b11,
		RX_STOP = 2'b10
	} rx_state_t;
endpackage

// ### design/byte_fifo.sv
/*
 * synchronous byte fifo with valid/ready on both sides.
 * optional overwrite of the newest entry when full.
 */
module byte_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic flush_i,
	input wire logic overwrite_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic full_o,
	output logic empty_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] rd_ptr_reg;
	logic [AW-1:0] wr_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;
	logic over;
	logic [AW-1:0] last_ptr;

	assign full_o = count_reg == (AW+1)'(DEPTH);
	assign empty_o = count_reg == '0;
	assign in_ready_o = !full_o || overwrite_i;
	assign out_valid_o = !empty_o;
	assign out_data_o = mem_reg[rd_ptr_reg];
	assign pop = out_valid_o && out_ready_i;
	assign push = in_valid_i && (!full_o || pop);
	assign over = in_valid_i && full_o && !pop && overwrite_i;
	assign last_ptr = (wr_ptr_reg == '0) ? AW'(DEPTH - 1) : wr_ptr_reg - AW'(1);

	always_ff @(posedge core_clk_i) begin
		if (ce_i && push)
			mem_reg[wr_ptr_reg] <= in_data_i;
		else if (ce_i && over)
			mem_reg[last_ptr] <= in_data_i;
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			count_reg <= '0;
		end else if (ce_i) begin
			if (flush_i) begin
				rd_ptr_reg <= '0;
				wr_ptr_reg <= '0;
				count_reg <= '0;
			end else begin
				if (push)
					wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
				if (pop)
					rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
				if (push && !pop)
					count_reg <= count_reg + (AW+1)'(1);
				else if (pop && !push)
					count_reg <= count_reg - (AW+1)'(1);
			end
		end
	end
endmodule

// ### design/midi_uart_port.sv
/*
 * midi uart port emulation: two host byte locations, transmit and receive
 * fifos, a command monitor with acknowledges, and the 31.25k serial link.
 * assumes one-cycle host read/write strobes on core_clk_i; serial input is
 * asynchronous and synchronised here.
 */
// How it works
// - ten-bit decode of two locations, upper bits zero
// - offset 0 data, offset 1 command/status
// - sixteen-entry transmit and receive fifos
// - receive push raises host interrupt
// - data port read clears pending interrupt
// - receive fifo fed by serial and acknowledges
// - serial link fixed at 31.25k baud
// - one start, eight data, one stop
// - reset leaves interface in non-uart mode
// - non-uart mode drops data port writes
// - non-uart reads return last received byte
// - 3F enters uart mode, pushes FE
// - A0-A7/AB/AC/AD/AF push FE then reply
// - other non-uart commands push FE only
// - uart mode queues and sends transmit bytes
// - status bit 6 tracks transmit fifo
// - uart reads pop; full overwrites last entry
// - status bit 7 tracks receive fifo
// - FF returns to non-uart mode
// - other uart-mode commands ignored silently
module midi_uart_port #(
	parameter logic [9:0] MIDI_PORT_BASE = midi_uart_pkg::BASE_DEFAULT,
	parameter int unsigned FIFO_DEPTH = midi_uart_pkg::FIFO_DEPTH
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire midi_uart_pkg::host_req_t host_req_i,
	output logic [7:0] host_rdata_o,
	output logic host_sel_o,
	output logic irq_o,
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	output logic uart_mode_o
);
	localparam int unsigned BC = midi_uart_pkg::BIT_CYCLES;
	localparam int unsigned HALF = BC / 2;
	logic hit;
	logic wr_data;
	logic wr_cmd;
	logic rd_data;
	logic rd_cmd;
	logic uart_mode_reg;
	logic irq_reg;
	logic [7:0] last_rx_reg;
	logic reply_pend_reg;
	logic [7:0] reply_reg;
	logic ack_push;
	logic [7:0] ack_byte;
	logic serial_push;
	logic [7:0] serial_byte;
	logic rx_in_valid;
	logic [7:0] rx_in_data;
	logic rx_out_valid;
	logic rx_pop;
	logic [7:0] rx_out_data;
	logic rx_empty;
	logic rx_in_ready;
	logic tx_out_valid;
	logic tx_pop;
	logic [7:0] tx_out_data;
	logic tx_full;
	logic is_reply_cmd;
	logic [7:0] reply_val;
	logic [7:0] cmd;

	// address decode, upper bits must be zero so no alias answers
	assign hit = host_req_i.addr[midi_uart_pkg::ADDR_W-1:midi_uart_pkg::DECODE_W] == '0 &&
		host_req_i.addr[9:1] == MIDI_PORT_BASE[9:1];
	assign wr_data = ce_i && hit && host_req_i.wr && host_req_i.addr[0] == midi_uart_pkg::OFFSET_DATA;
	assign wr_cmd = ce_i && hit && host_req_i.wr && host_req_i.addr[0] == midi_uart_pkg::OFFSET_CMD;
	assign rd_data = ce_i && hit && host_req_i.rd && host_req_i.addr[0] == midi_uart_pkg::OFFSET_DATA;
	assign rd_cmd = ce_i && hit && host_req_i.rd && host_req_i.addr[0] == midi_uart_pkg::OFFSET_CMD;
	assign host_sel_o = hit && (host_req_i.rd || host_req_i.wr);
	assign cmd = host_req_i.wdata;
	assign uart_mode_o = uart_mode_reg;
	assign irq_o = irq_reg;

	// command monitor decode of reply-producing commands
	always_comb begin
		is_reply_cmd = 1'b1;
		reply_val = midi_uart_pkg::REPLY_ZERO;
		if (cmd[7:3] == midi_uart_pkg::CMD_A_GROUP && !cmd[3] ||
				cmd == midi_uart_pkg::CMD_AB) begin
			reply_val = midi_uart_pkg::REPLY_ZERO;
		end else if (cmd == midi_uart_pkg::CMD_AC) begin
			reply_val = midi_uart_pkg::REPLY_AC;
		end else if (cmd == midi_uart_pkg::CMD_AD) begin
			reply_val = midi_uart_pkg::REPLY_AD;
		end else if (cmd == midi_uart_pkg::CMD_AF) begin
			reply_val = midi_uart_pkg::REPLY_AF;
		end else begin
			is_reply_cmd = 1'b0;
		end
	end

	// mode register
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			uart_mode_reg <= 1'b0;
		else if (wr_cmd && !uart_mode_reg && cmd == midi_uart_pkg::CMD_ENTER_UART)
			uart_mode_reg <= 1'b1;
		else if (wr_cmd && uart_mode_reg && cmd == midi_uart_pkg::CMD_LEAVE_UART)
			uart_mode_reg <= 1'b0;
	end

	// acknowledge and queued reply; reply follows the ack in the next cycle free of ack and serial pushes
	assign ack_push = wr_cmd && !uart_mode_reg;
	assign ack_byte = midi_uart_pkg::ACK_BYTE;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reply_pend_reg <= 1'b0;
			reply_reg <= 8'h00;
		end else if (ce_i) begin
			if (ack_push && is_reply_cmd) begin
				reply_pend_reg <= 1'b1;
				reply_reg <= reply_val;
			end else if (reply_pend_reg && !ack_push && !serial_push) begin
				reply_pend_reg <= 1'b0;
			end
		end
	end

	// receive fifo source mux: ack first, then serial, then pending reply
	always_comb begin
		rx_in_valid = 1'b0;
		rx_in_data = 8'h00;
		if (ack_push) begin
			rx_in_valid = 1'b1;
			rx_in_data = ack_byte;
		end else if (serial_push) begin
			rx_in_valid = 1'b1;
			rx_in_data = serial_byte;
		end else if (reply_pend_reg) begin
			rx_in_valid = ce_i;
			rx_in_data = reply_reg;
		end
	end

	// non-uart reads leave the fifo alone and show the last received byte
	assign rx_pop = rd_data && uart_mode_reg;

	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.flush_i(1'b0),
		.overwrite_i(1'b1),
		.in_valid_i(rx_in_valid),
		.in_ready_o(rx_in_ready),
		.in_data_i(rx_in_data),
		.out_valid_o(rx_out_valid),
		.out_ready_i(rx_pop),
		.out_data_o(rx_out_data),
		.full_o(),
		.empty_o(rx_empty)
	);

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			last_rx_reg <= 8'h00;
		else if (ce_i && rx_in_valid && rx_in_ready)
			last_rx_reg <= rx_in_data;
	end

	// interrupt: set on any push wins over the clearing read
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			irq_reg <= 1'b0;
		else if (ce_i && rx_in_valid && rx_in_ready)
			irq_reg <= 1'b1;
		else if (rd_data)
			irq_reg <= 1'b0;
	end

	// read data register
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			host_rdata_o <= 8'h00;
		end else if (rd_data) begin
			host_rdata_o <= uart_mode_reg ? (rx_out_valid ? rx_out_data : last_rx_reg) : last_rx_reg;
		end else if (rd_cmd) begin
			host_rdata_o <= 8'h00;
			host_rdata_o[midi_uart_pkg::RXS_BIT] <= rx_empty;
			host_rdata_o[midi_uart_pkg::TXS_BIT] <= tx_full;
		end
	end

	// transmit fifo: only uart-mode data writes enter; full drops the byte
	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.flush_i(1'b0),
		.overwrite_i(1'b0),
		.in_valid_i(wr_data && uart_mode_reg),
		.in_ready_o(),
		.in_data_i(host_req_i.wdata),
		.out_valid_o(tx_out_valid),
		.out_ready_i(tx_pop),
		.out_data_o(tx_out_data),
		.full_o(tx_full),
		.empty_o()
	);

	// serial transmitter
	midi_uart_pkg::tx_state_t tx_state_reg;
	logic [$clog2(BC)-1:0] tx_cnt_reg;
	logic [2:0] tx_bit_reg;
	logic [7:0] tx_sh_reg;
	logic tx_tick;

	assign tx_tick = tx_cnt_reg == ($clog2(BC))'(BC - 1);
	assign tx_pop = ce_i && tx_state_reg == midi_uart_pkg::TX_IDLE && tx_out_valid;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_state_reg <= midi_uart_pkg::TX_IDLE;
			tx_cnt_reg <= '0;
			tx_bit_reg <= '0;
			tx_sh_reg <= 8'h00;
			serial_out_pin_o <= 1'b1;
		end else if (ce_i) begin
			tx_cnt_reg <= (tx_state_reg == midi_uart_pkg::TX_IDLE || tx_tick) ? '0 : tx_cnt_reg + ($clog2(BC))'(1);
			case (tx_state_reg)
				midi_uart_pkg::TX_IDLE: begin
					serial_out_pin_o <= 1'b1;
					if (tx_out_valid) begin
						tx_sh_reg <= tx_out_data;
						serial_out_pin_o <= 1'b0;
						tx_state_reg <= midi_uart_pkg::TX_START;
					end
				end
				midi_uart_pkg::TX_START: begin
					if (tx_tick) begin
						serial_out_pin_o <= tx_sh_reg[0];
						tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
						tx_bit_reg <= '0;
						tx_state_reg <= midi_uart_pkg::TX_DATA;
					end
				end
				midi_uart_pkg::TX_DATA: begin
					if (tx_tick) begin
						if (tx_bit_reg == 3'd7) begin
							serial_out_pin_o <= 1'b1;
							tx_state_reg <= midi_uart_pkg::TX_STOP;
						end else begin
							serial_out_pin_o <= tx_sh_reg[0];
							tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
							tx_bit_reg <= tx_bit_reg + 3'd1;
						end
					end
				end
				midi_uart_pkg::TX_STOP: begin
					if (tx_tick)
						tx_state_reg <= midi_uart_pkg::TX_IDLE;
				end
				default: tx_state_reg <= midi_uart_pkg::TX_IDLE;
			endcase
		end
	end

	// serial receiver behind a two-stage synchroniser
	logic sync1_reg;
	logic sync2_reg;
	midi_uart_pkg::rx_state_t rx_state_reg;
	logic [$clog2(BC)-1:0] rx_cnt_reg;
	logic [2:0] rx_bit_reg;
	logic [7:0] rx_sh_reg;
	logic rx_done_reg;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else if (ce_i) begin
			sync1_reg <= serial_in_pin_i;
			sync2_reg <= sync1_reg;
		end
	end

	assign serial_push = rx_done_reg && ce_i;
	assign serial_byte = rx_sh_reg;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_state_reg <= midi_uart_pkg::RX_IDLE;
			rx_cnt_reg <= '0;
			rx_bit_reg <= '0;
			rx_sh_reg <= 8'h00;
			rx_done_reg <= 1'b0;
		end else if (ce_i) begin
			rx_done_reg <= 1'b0;
			rx_cnt_reg <= rx_cnt_reg + ($clog2(BC))'(1);
			case (rx_state_reg)
				midi_uart_pkg::RX_IDLE: begin
					rx_cnt_reg <= '0;
					if (!sync2_reg)
						rx_state_reg <= midi_uart_pkg::RX_START;
				end
				midi_uart_pkg::RX_START: begin
					if (rx_cnt_reg == ($clog2(BC))'(HALF)) begin
						rx_cnt_reg <= '0;
						rx_bit_reg <= '0;
						rx_state_reg <= sync2_reg ? midi_uart_pkg::RX_IDLE : midi_uart_pkg::RX_DATA;
					end
				end
				midi_uart_pkg::RX_DATA: begin
					if (rx_cnt_reg == ($clog2(BC))'(BC - 1)) begin
						rx_cnt_reg <= '0;
						rx_sh_reg <= {sync2_reg, rx_sh_reg[7:1]};
						rx_bit_reg <= rx_bit_reg + 3'd1;
						if (rx_bit_reg == 3'd7)
							rx_state_reg <= midi_uart_pkg::RX_STOP;
					end
				end
				midi_uart_pkg::RX_STOP: begin
					if (rx_cnt_reg == ($clog2(BC))'(BC - 1)) begin
						rx_done_reg <= sync2_reg;
						rx_state_reg <= midi_uart_pkg::RX_IDLE;
					end
				end
				default: rx_state_reg <= midi_uart_pkg::RX_IDLE;
			endcase
		end
	end
endmodule

// ### testbench/midi_uart_port_sva.sv
/* concurrent checks on the pins of the midi uart port.
 * assumes ce_i stays high and one-cycle host strobes. */
module midi_uart_port_chk #(
	parameter logic [9:0] MIDI_PORT_BASE = midi_uart_pkg::BASE_DEFAULT
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire midi_uart_pkg::host_req_t host_req_i,
	input wire logic [7:0] host_rdata_o,
	input wire logic host_sel_o,
	input wire logic irq_o,
	input wire logic serial_in_pin_i,
	input wire logic serial_out_pin_o,
	input wire logic uart_mode_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	wire logic rd_hit = host_sel_o && ce_i && host_req_i.rd;
	wire logic cmd_wr = host_sel_o && ce_i && host_req_i.wr && host_req_i.addr[0];
	wire logic dat_rd = rd_hit && !host_req_i.addr[0];
	int unsigned low_cnt;
	// cycles the line has spent low since it last left the mark level
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			low_cnt <= 0;
		else if (serial_out_pin_o)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	end
	a_sel_decode: assert property (
		host_sel_o == ((host_req_i.rd || host_req_i.wr) && host_req_i.addr[15:10] == 6'h00
		&& host_req_i.addr[9:1] == MIDI_PORT_BASE[9:1]))
		else $error("host select does not match the address decode");
	a_reset_state: assert property ($rose(rstn_i) |-> !uart_mode_o && !irq_o && serial_out_pin_o)
		else $error("state after reset is wrong");
	a_enter_uart: assert property (cmd_wr && !uart_mode_o && host_req_i.wdata == 8'h3F |=> uart_mode_o && irq_o)
		else $error("enter command did not switch mode and acknowledge");
	a_ack_raise: assert property (cmd_wr && !uart_mode_o |=> irq_o)
		else $error("command without acknowledge interrupt");
	a_leave_uart: assert property (cmd_wr && uart_mode_o && host_req_i.wdata == 8'hFF |=> !uart_mode_o)
		else $error("leave command did not return to command mode");
	a_uart_cmd_quiet: assert property (
		cmd_wr && uart_mode_o && host_req_i.wdata != 8'hFF && !irq_o |=> !irq_o && uart_mode_o)
		else $error("ignored command had an effect");
	a_irq_clear: assert property (dat_rd |=> !irq_o)
		else $error("data read did not clear the interrupt");
	a_rdata_hold: assert property (!rd_hit |=> $stable(host_rdata_o))
		else $error("read data changed without a read");
	a_start_hold: assert property ($fell(serial_out_pin_o) |=> !serial_out_pin_o [*8])
		else $error("start bit too short");
	a_bit_time: assert property ($rose(serial_out_pin_o) |-> low_cnt % midi_uart_pkg::BIT_CYCLES == 0)
		else $error("low stretch is not a whole number of bit times");
	c_enter: cover property (cmd_wr && host_req_i.wdata == 8'h3F);
	c_tx: cover property ($fell(serial_out_pin_o));
	c_irq: cover property ($rose(irq_o));
endmodule

bind midi_uart_port midi_uart_port_chk #(.MIDI_PORT_BASE(MIDI_PORT_BASE)) chk (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .host_req_i(host_req_i), .host_rdata_o(host_rdata_o),
	.host_sel_o(host_sel_o), .irq_o(irq_o), .serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
	.uart_mode_o(uart_mode_o));

// ### testbench/midi_peer.sv
/* far end of the midi link: sends frames on request and reports each frame heard.
 * assumes the core clock rate of the package. */
module midi_peer (
	input wire logic core_clk_i,
	input wire logic line_i,
	output logic line_o,
	output logic got_o,
	output logic [8:0] byte_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned BC = midi_uart_pkg::BIT_CYCLES;
	logic [8:0] sh;
	initial begin
		line_o = 1'b1;
		got_o = 1'b0;
		byte_o = 9'h000;
	end
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk_i);
			line_o <= f[i];
			repeat (BC - 1) @(posedge core_clk_i);
		end
	endtask
	// samples mid-bit; bit 8 of the report is the stop bit
	always begin
		@(negedge line_i);
		repeat (BC / 2) @(posedge core_clk_i);
		for (int i = 0; i < 9; i++) begin
			repeat (BC) @(posedge core_clk_i);
			sh[i] = line_i;
		end
		byte_o <= sh;
		got_o <= 1'b1;
		@(posedge core_clk_i);
		got_o <= 1'b0;
	end
endmodule

// ### testbench/tb_midi_uart_port_emulation.sv
/* self-checking bench for the midi uart port emulation.
 * assumes the peer model and the bound checker are compiled with it. */
module tb_midi_uart_port_emulation;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] DAT = 16'h0330;
	localparam logic [15:0] CMD = 16'h0331;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	midi_uart_pkg::host_req_t host_req = '0;
	logic [7:0] host_rdata_o;
	logic host_sel_o, irq_o, serial_in, serial_out, uart_mode_o, got;
	logic [8:0] got_byte;
	logic rd_seen = 1'b0;
	logic [7:0] exp_rd[$];
	logic [8:0] exp_ser[$];
	// expected receive fifo contents, newest overwrites the last entry when full
	logic [7:0] rx_model[$];
	logic ce = 1'b1;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	int seed = 75795;
	logic [7:0] txb, rxb, c;
	always #5 core_clk_i = ~core_clk_i;
	midi_uart_port uut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce), .host_req_i(host_req),
		.host_rdata_o(host_rdata_o), .host_sel_o(host_sel_o), .irq_o(irq_o), .serial_in_pin_i(serial_in),
		.serial_out_pin_o(serial_out), .uart_mode_o(uart_mode_o));
	midi_peer peer (.core_clk_i(core_clk_i), .line_i(serial_out), .line_o(serial_in), .got_o(got),
		.byte_o(got_byte));
	task automatic cmp_val(input string n, input logic [8:0] e, input logic [8:0] s);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmp_flag(input string n, input logic e, input logic s);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %b seen %b", n, e, s);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		host_req <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge core_clk_i);
		host_req <= '0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_rd.push_back(e);
		acc(1'b0, a, 8'h00);
	endtask
	task automatic done(input string t);
		$display("test %s finished", t);
	endtask
	task automatic note_rx(input logic [7:0] v);
		if (rx_model.size() == midi_uart_pkg::FIFO_DEPTH)
			rx_model[midi_uart_pkg::FIFO_DEPTH - 1] = v;
		else
			rx_model.push_back(v);
	endtask
	function automatic logic [7:0] reply(input logic [7:0] v);
		if (v == 8'hAC)
			return 8'h15;
		if (v == 8'hAD)
			return 8'h01;
		if (v == 8'hAF)
			return 8'h64;
		if (v == 8'hAB || v[7:3] == 5'h14)
			return 8'h00;
		return 8'hFE;
	endfunction
	task automatic conclude;
		if (exp_rd.size() + exp_ser.size() > 0) begin
			error_cnt++;
			$display("mismatch pending expected 0 seen %0d", exp_rd.size() + exp_ser.size());
		end
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// results: read data one cycle after a taken read, and frames heard by the peer
	always @(posedge core_clk_i) begin
		rd_seen <= host_req.rd && host_sel_o;
		if (rd_seen && exp_rd.size() > 0)
			cmp_val("rdata", {1'b0, exp_rd.pop_front()}, {1'b0, host_rdata_o});
		if (got && exp_ser.size() > 0)
			cmp_val("serial", exp_ser.pop_front(), got_byte);
	end
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		txb = 8'($random(seed));
		rxb = 8'($random(seed));
		repeat (4) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		rd(CMD, 8'h80);
		@(negedge core_clk_i);
		cmp_flag("mode", 1'b0, uart_mode_o);
		done("reset");
		acc(1'b1, 16'h0731, 8'h3F);
		acc(1'b1, 16'h0333, 8'h3F);
		@(negedge core_clk_i);
		cmp_flag("mode", 1'b0, uart_mode_o);
		done("decode");
		acc(1'b1, CMD, 8'h3F);
		@(negedge core_clk_i);
		cmp_flag("mode", 1'b1, uart_mode_o);
		cmp_flag("irq", 1'b1, irq_o);
		rd(DAT, 8'hFE);
		@(negedge core_clk_i);
		cmp_flag("irq", 1'b0, irq_o);
		acc(1'b1, CMD, 8'h12);
		@(negedge core_clk_i);
		cmp_flag("irq", 1'b0, irq_o);
		rd(CMD, 8'h80);
		done("enter");
		exp_ser.push_back({1'b1, txb});
		fork
			peer.send(rxb);
		join_none
		acc(1'b1, DAT, txb);
		for (int i = 0; i < 16; i++)
			acc(1'b1, DAT, 8'($random(seed)));
		rd(CMD, 8'hC0);
		for (int i = 0; i < 40000 && exp_ser.size() > 0; i++)
			@(posedge core_clk_i);
		for (int i = 0; i < 4000 && irq_o !== 1'b1; i++)
			@(posedge core_clk_i);
		@(negedge core_clk_i);
		cmp_flag("irq", 1'b1, irq_o);
		rd(DAT, rxb);
		acc(1'b1, CMD, 8'hFF);
		@(negedge core_clk_i);
		cmp_flag("mode", 1'b0, uart_mode_o);
		done("uart");
		@(posedge core_clk_i);
		rstn_i <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		@(negedge core_clk_i);
		cmp_flag("line", 1'b1, serial_out);
		done("second reset");
		@(posedge core_clk_i);
		ce <= 1'b0;
		acc(1'b1, CMD, 8'h3F);
		@(negedge core_clk_i);
		cmp_flag("frozen", 1'b0, uart_mode_o);
		@(posedge core_clk_i);
		ce <= 1'b1;
		done("clock enable");
		for (int i = 0; i < 18; i++) begin
			c = (i < 16) ? 8'hA0 + 8'(i) : ((i == 16) ? 8'hFF : 8'($random(seed)));
			if (c == 8'h3F)
				c = 8'h00;
			acc(1'b1, CMD, c);
			note_rx(8'hFE);
			if (reply(c) != 8'hFE)
				note_rx(reply(c));
			@(posedge core_clk_i);
			@(negedge core_clk_i);
			cmp_flag("irq", 1'b1, irq_o);
			acc(1'b1, DAT, 8'h5A);
			rd(DAT, reply(c));
		end
		@(negedge core_clk_i);
		cmp_flag("line", 1'b1, serial_out);
		done("commands");
		note_rx(8'hFE);
		acc(1'b1, CMD, 8'h3F);
		while (rx_model.size() > 0)
			rd(DAT, rx_model.pop_front());
		rd(CMD, 8'h80);
		repeat (2) @(posedge core_clk_i);
		done("overflow");
		conclude();
	end
endmodule
